/* File: spi_prog_target.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_prog_target #(
	parameter int unsigned FUSE_WAIT_CYC  = spi_prog_pkg::WD_FUSE_CYC,
	parameter int unsigned FLASH_WAIT_CYC = spi_prog_pkg::WD_FLASH_CYC,
	parameter int unsigned EE_WAIT_CYC    = spi_prog_pkg::WD_EEPROM_CYC,
	parameter int unsigned ERASE_WAIT_CYC = spi_prog_pkg::WD_ERASE_CYC
) (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              srst_i,
	// serial link
	spi_prog_link_if.target        link,
	// configuration and status toward the chip
	output logic                   prog_mode_o,
	output logic                   busy_o,
	output logic [5:0]             lock_bits_o,
	output logic [7:0]             fuse_low_o,
	output logic [7:0]             fuse_high_o,
	output logic [3:0]             fuse_ext_o
);
	// background array walks
	typedef enum logic [1:0] {
		WALK_NONE  = 2'b00,
		WALK_ERASE = 2'b01,
		WALK_FLASH = 2'b10,
		WALK_EE    = 2'b11
	} walk_type;

	typedef struct packed {
		logic [1:0]                 sck_sync;	// bit 0 first stage, bit 1 second
		logic [1:0]                 mosi_sync;
		logic [1:0]                 rst_sync;
		logic                       sck_prev;	// last synced sck level
		logic                       enabled;	// programming enable seen
		logic [4:0]                 bit_cnt;	// bit within the instruction
		logic [31:0]                rx;	// incoming shift register
		logic [7:0]                 tx;	// outgoing byte
		logic                       miso;
		logic [spi_prog_pkg::WAIT_W-1:0] wait_cnt;	// self-timed wait
		walk_type                   walk;
		logic [15:0]                walk_idx;
		logic [8:0]                 walk_page;
		logic                       busy;
		logic [5:0]                 lock;
		logic [7:0]                 fuse_lo;
		logic [7:0]                 fuse_hi;
		logic [3:0]                 fuse_ext;
	} state_type;

	state_type r;	// registered state
	state_type next_r;	// next state

	// memories; flash is word wide, buffers hold one page each
	logic [15:0] flash [0:(1<<spi_prog_pkg::FLASH_AW)-1];
	logic [7:0]  eeprom [0:(1<<spi_prog_pkg::EE_AW)-1];
	logic [15:0] fbuf [0:(1<<spi_prog_pkg::FPAGE_AW)-1];
	logic [7:0]  ebuf [0:(1<<spi_prog_pkg::EPAGE_AW)-1];

	// single-location write strobes from the decoder
	logic        fbuf_we;	// page buffer half write
	logic        fbuf_hi;	// which half
	logic        ee_we;	// eeprom byte write
	logic        ebuf_we;	// eeprom page buffer write
	logic [31:0] word;	// instruction incl. the bit being sampled
	logic        rise;	// synced sck rising edge
	logic        fall;	// synced sck falling edge
	logic [7:0]  rd_byte;	// answer for byte four

	// pick the answer for byte four from the first three bytes
	function automatic logic [7:0] answer(input logic [23:0] w, input state_type s,
		input logic [15:0] fw, input logic [7:0] eb);
		logic [7:0] b1;
		logic [7:0] b2;
		b1 = w[23:16];
		b2 = w[15:8];
		answer = w[7:0];	// echo when nothing is read
		if (s.enabled) begin
			if ((b1 & spi_prog_pkg::HALF_MASK) == spi_prog_pkg::OP_READ_FLASH)
				answer = b1[spi_prog_pkg::HALF_BIT] ? fw[15:8] : fw[7:0];
			else if (b1 == spi_prog_pkg::OP_EE_READ)
				answer = eb;
			else if (b1 == spi_prog_pkg::OP_READ_LOCK_FHI && b2 == spi_prog_pkg::SEL_READ_A)
				answer = {2'b11, s.lock};
			else if (b1 == spi_prog_pkg::OP_READ_LOCK_FHI && b2 == spi_prog_pkg::SEL_READ_B)
				answer = s.fuse_hi;
			else if (b1 == spi_prog_pkg::OP_READ_FLO_FEXT && b2 == spi_prog_pkg::SEL_READ_A)
				answer = s.fuse_lo;
			else if (b1 == spi_prog_pkg::OP_READ_FLO_FEXT && b2 == spi_prog_pkg::SEL_READ_B)
				answer = {4'hf, s.fuse_ext};
			else if (b1 == spi_prog_pkg::OP_POLL)
				answer = {7'h00, s.busy};
		end
	endfunction

	// read ports; address is b2:b3, eeprom takes only its implemented bits
	assign word    = {r.rx[30:0], r.mosi_sync[1]};
	assign rd_byte = answer(word[23:0], r, flash[word[15:0]], eeprom[word[11:0]]);

	// next-state logic
	always_comb begin
		next_r = r;
		fbuf_we = 1'b0;
		fbuf_hi = 1'b0;
		ee_we = 1'b0;
		ebuf_we = 1'b0;
		rise = r.sck_sync[1] & ~r.sck_prev;
		fall = ~r.sck_sync[1] & r.sck_prev;
		next_r.sck_sync = {r.sck_sync[0], link.sck};
		next_r.mosi_sync = {r.mosi_sync[0], link.mosi};
		next_r.rst_sync = {r.rst_sync[0], link.rst_n};
		next_r.sck_prev = r.sck_sync[1];

		// self-timed wait counts down; a walk steps one location a cycle
		if (r.wait_cnt != '0)
			next_r.wait_cnt = r.wait_cnt - 1'b1;
		if (r.walk != WALK_NONE) begin
			next_r.walk_idx = r.walk_idx + 1'b1;
			if ((r.walk == WALK_ERASE && r.walk_idx == 16'hffff) ||
			    (r.walk == WALK_FLASH && r.walk_idx == 16'h007f) ||
			    (r.walk == WALK_EE && r.walk_idx == 16'h0007))
				next_r.walk = WALK_NONE;
		end

		if (r.rst_sync[1]) begin
			// link reset released: drop any partial instruction and leave programming mode
			next_r.bit_cnt = '0;
			next_r.rx = '0;
			next_r.tx = '0;
			next_r.miso = 1'b0;
			next_r.enabled = 1'b0;
		end else begin
			if (rise) begin
				// sample on the rising edge, msb first
				next_r.rx = word;
				next_r.bit_cnt = r.bit_cnt + 1'b1;
				// at each byte end load the byte to send next; echo gives sync check
				if (r.bit_cnt[2:0] == 3'h7)
					next_r.tx = (r.bit_cnt == 5'd23) ? rd_byte : word[7:0];
				if (r.bit_cnt == 5'd31) begin
					if (word[31:24] == spi_prog_pkg::OP_ACCESS && word[23:16] == spi_prog_pkg::SEL_ENABLE)
						next_r.enabled = 1'b1;
					else if (r.enabled && !r.busy) begin
						// programming steps are refused while a previous one runs
						unique case (word[31:24])
							spi_prog_pkg::OP_LOAD_PAGE,
							spi_prog_pkg::OP_LOAD_PAGE | 8'h08: begin
								fbuf_we = 1'b1;
								fbuf_hi = word[24 + spi_prog_pkg::HALF_BIT];
							end
							spi_prog_pkg::OP_WRITE_PAGE: begin
								next_r.walk = WALK_FLASH;
								next_r.walk_idx = '0;
								next_r.walk_page = {word[23:16], word[15]};	// byte two and top bit of byte three
								next_r.wait_cnt = spi_prog_pkg::WAIT_W'(FLASH_WAIT_CYC);
							end
							spi_prog_pkg::OP_EE_WRITE: begin
								ee_we = 1'b1;
								next_r.wait_cnt = spi_prog_pkg::WAIT_W'(EE_WAIT_CYC);
							end
							spi_prog_pkg::OP_EE_LOAD: ebuf_we = 1'b1;
							spi_prog_pkg::OP_EE_PAGE: begin
								next_r.walk = WALK_EE;
								next_r.walk_idx = '0;
								next_r.walk_page = {word[19:16], word[15:11]};	// nibble of byte two, top of byte three
								next_r.wait_cnt = spi_prog_pkg::WAIT_W'(EE_WAIT_CYC);
							end
							spi_prog_pkg::OP_ACCESS: begin
								if (word[23:21] == spi_prog_pkg::SEL_ERASE) begin
									next_r.walk = WALK_ERASE;
									next_r.walk_idx = '0;
									next_r.lock = spi_prog_pkg::LOCK_RST;
									next_r.wait_cnt = spi_prog_pkg::WAIT_W'(ERASE_WAIT_CYC);
								end else if (word[23:21] == spi_prog_pkg::SEL_LOCK) begin
									next_r.lock = word[5:0];
									next_r.wait_cnt = spi_prog_pkg::WAIT_W'(FUSE_WAIT_CYC);
								end else if (word[23:16] == spi_prog_pkg::SEL_FUSE_LO) begin
									next_r.fuse_lo = word[7:0];
									next_r.wait_cnt = spi_prog_pkg::WAIT_W'(FUSE_WAIT_CYC);
								end else if (word[23:16] == spi_prog_pkg::SEL_FUSE_HI) begin
									next_r.fuse_hi = word[7:0];
									next_r.wait_cnt = spi_prog_pkg::WAIT_W'(FUSE_WAIT_CYC);
								end else if (word[23:16] == spi_prog_pkg::SEL_FUSE_EXT) begin
									next_r.fuse_ext = word[3:0];
									next_r.wait_cnt = spi_prog_pkg::WAIT_W'(FUSE_WAIT_CYC);
								end
							end
							default: ;	// reads and poll act at byte three only
						endcase
					end
				end
			end
			if (fall) begin
				// shift the answer out on the falling edge
				next_r.miso = r.tx[7];
				next_r.tx = {r.tx[6:0], 1'b0};
			end
		end
		next_r.busy = (next_r.wait_cnt != '0) || (next_r.walk != WALK_NONE);
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '0;
			r.sck_sync <= 2'b00;
			r.rst_sync <= 2'b11;	// link reset counts as released
			r.sck_prev <= 1'b0;
			r.lock <= spi_prog_pkg::LOCK_RST;
			r.fuse_lo <= spi_prog_pkg::FUSE_LO_RST;
			r.fuse_hi <= spi_prog_pkg::FUSE_HI_RST;
			r.fuse_ext <= spi_prog_pkg::FUSE_EXT_RST;
			r.walk <= WALK_NONE;
		end else begin
			r <= next_r;
		end
	end

	// array writes; no reset, contents model non-volatile cells
	always_ff @(posedge clk_sys_i) begin
		if (fbuf_we) begin
			// each half written on its own, so the low-then-high order is the programmer's
			if (fbuf_hi)
				fbuf[word[14:8]][15:8] <= word[7:0];
			else
				fbuf[word[14:8]][7:0] <= word[7:0];	// word index from byte three
		end
		if (ebuf_we)
			ebuf[word[10:8]] <= word[7:0];
		if (ee_we)
			eeprom[word[19:8]] <= word[7:0];
		unique case (r.walk)
			WALK_ERASE: begin
				flash[r.walk_idx] <= {spi_prog_pkg::ERASED_BYTE, spi_prog_pkg::ERASED_BYTE};
				eeprom[r.walk_idx[11:0]] <= spi_prog_pkg::ERASED_BYTE;
			end
			WALK_FLASH: flash[{r.walk_page, r.walk_idx[6:0]}] <= fbuf[r.walk_idx[6:0]];
			WALK_EE: eeprom[{r.walk_page, r.walk_idx[2:0]}] <= ebuf[r.walk_idx[2:0]];
			WALK_NONE: ;
		endcase
	end

	// outputs straight from the state register
	assign link.miso   = r.miso;
	assign prog_mode_o = r.enabled;
	assign busy_o      = r.busy;
	assign lock_bits_o = r.lock;
	assign fuse_low_o  = r.fuse_lo;
	assign fuse_high_o = r.fuse_hi;
	assign fuse_ext_o  = r.fuse_ext;
endmodule
`default_nettype wire

/* File: spi_prog_pkg.sv */
// shared constants for the serial programming link and its two ends
`default_nettype none
package spi_prog_pkg;

	// system clock
	localparam int unsigned CLK_PERIOD_NS   = 8;

	// least wait after each kind of self-timed programming step, in ns
	localparam int unsigned T_WD_FUSE_NS    = 4500000;
	localparam int unsigned T_WD_FLASH_NS   = 4500000;
	localparam int unsigned T_WD_EEPROM_NS  = 9000000;
	localparam int unsigned T_WD_ERASE_NS   = 9000000;

	// the same waits in clock cycles, least times rounded up
	localparam int unsigned WD_FUSE_CYC     = (T_WD_FUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WD_FLASH_CYC    = (T_WD_FLASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WD_EEPROM_CYC   = (T_WD_EEPROM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WD_ERASE_CYC    = (T_WD_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAIT_W          = 21;

	// first-byte opcodes (load and read flash carry the half select in bit 3)
	localparam logic [7:0] OP_LOAD_PAGE     = 8'h40;
	localparam logic [7:0] OP_WRITE_PAGE    = 8'h4c;
	localparam logic [7:0] OP_READ_FLASH    = 8'h20;
	localparam logic [7:0] OP_EE_READ       = 8'ha0;
	localparam logic [7:0] OP_EE_WRITE      = 8'hc0;
	localparam logic [7:0] OP_EE_LOAD       = 8'hc1;
	localparam logic [7:0] OP_EE_PAGE       = 8'hc2;
	localparam logic [7:0] OP_READ_LOCK_FHI = 8'h58;
	localparam logic [7:0] OP_READ_FLO_FEXT = 8'h50;
	localparam logic [7:0] OP_ACCESS        = 8'hac;
	localparam logic [7:0] OP_POLL          = 8'hf0;
	localparam logic [7:0] HALF_MASK        = 8'hf7;
	localparam int unsigned HALF_BIT        = 3;

	// second-byte selectors
	localparam logic [7:0] SEL_ENABLE       = 8'h53;
	localparam logic [7:0] SEL_FUSE_LO      = 8'ha0;
	localparam logic [7:0] SEL_FUSE_HI      = 8'ha8;
	localparam logic [7:0] SEL_FUSE_EXT     = 8'ha4;
	localparam logic [7:0] SEL_READ_A       = 8'h00;
	localparam logic [7:0] SEL_READ_B       = 8'h08;
	localparam logic [2:0] SEL_ERASE        = 3'b100;
	localparam logic [2:0] SEL_LOCK         = 3'b111;

	// memory geometry (program_address_top_bit = 15, eeprom_address_top_bit = 11)
	localparam int unsigned FLASH_AW        = 16;
	localparam int unsigned EE_AW           = 12;
	localparam int unsigned FPAGE_AW        = 7;
	localparam int unsigned EPAGE_AW        = 3;

	// reset values of the configuration cells (all unprogrammed)
	localparam logic [5:0] LOCK_RST         = 6'h3f;
	localparam logic [7:0] FUSE_LO_RST      = 8'hff;
	localparam logic [7:0] FUSE_HI_RST      = 8'hff;
	localparam logic [3:0] FUSE_EXT_RST     = 4'hf;
	localparam logic [7:0] ERASED_BYTE      = 8'hff;

	// programmer side: serial clock half period and register map
	localparam logic [3:0] SCK_HALF_CYC     = 4'h8;
	localparam logic [3:0] REG_CMD          = 4'h0;
	localparam logic [3:0] REG_RESP         = 4'h4;
	localparam logic [3:0] REG_STATUS       = 4'h8;
	localparam logic [3:0] REG_CTRL         = 4'hc;
	localparam int unsigned STAT_BUSY_BIT   = 0;
	localparam int unsigned CTRL_HOLD_BIT   = 0;

endpackage
`default_nettype wire

/* File: spi_prog_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// the four wires between programmer and target
interface spi_prog_link_if;
	logic rst_n;	// target reset, low while programming
	logic sck;	// serial clock from the programmer
	logic mosi;	// data toward the target
	logic miso;	// data toward the programmer

	modport programmer (output rst_n, output sck, output mosi, input miso);
	modport target (input rst_n, input sck, input mosi, output miso);
endinterface
`default_nettype wire

/* File: spi_prog_programmer.sv */
`timescale 1ns/1ps
`default_nettype none
// programmer end: software writes a 32-bit instruction, the block shifts it out
module spi_prog_programmer (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	// register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	// serial link
	spi_prog_link_if.programmer link
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW  = 2'b01,
		ST_HIGH = 2'b10
	} phase_type;

	typedef struct packed {
		phase_type   phase;	// serial clock phase
		logic [3:0]  div;	// cycles within the half period
		logic [4:0]  bit_cnt;	// bit of the instruction
		logic [31:0] cmd;	// last instruction written
		logic [31:0] tx;	// outgoing shift
		logic [31:0] rx;	// incoming shift
		logic [31:0] resp;	// four bytes read back
		logic [1:0]  miso_sync;	// bit 0 first stage
		logic        hold;	// keeps the target in reset
		logic        sck;
		logic        mosi;
		logic [31:0] rdata;
	} state_type;

	state_type r;	// registered state
	state_type next_r;	// next state

	// next-state logic
	always_comb begin
		next_r = r;
		next_r.miso_sync = {r.miso_sync[0], link.miso};
		next_r.rdata = '0;	// unmapped reads return zero
		// register reads, answered one cycle later
		if (rd_i) begin
			unique case (addr_i)
				spi_prog_pkg::REG_CMD: next_r.rdata = r.cmd;
				spi_prog_pkg::REG_RESP: next_r.rdata = r.resp;
				spi_prog_pkg::REG_STATUS: next_r.rdata = {30'h0, r.hold, r.phase != ST_IDLE};
				spi_prog_pkg::REG_CTRL: next_r.rdata = {31'h0, r.hold};
				default: next_r.rdata = '0;
			endcase
		end
		// register writes; a command while shifting is dropped
		if (wr_i && addr_i == spi_prog_pkg::REG_CTRL)
			next_r.hold = wdata_i[spi_prog_pkg::CTRL_HOLD_BIT];
		if (wr_i && addr_i == spi_prog_pkg::REG_CMD && r.phase == ST_IDLE) begin
			// all four bytes always go out, echo or not
			next_r.cmd = wdata_i;
			next_r.tx = wdata_i;
			next_r.mosi = wdata_i[31];
			next_r.bit_cnt = '0;
			next_r.div = '0;
			next_r.phase = ST_LOW;
		end
		// serial clock from the system clock by a divider
		unique case (r.phase)
			ST_IDLE: next_r.sck = 1'b0;
			ST_LOW: begin
				next_r.div = r.div + 1'b1;
				if (r.div == spi_prog_pkg::SCK_HALF_CYC - 1'b1) begin
					next_r.div = '0;
					next_r.sck = 1'b1;
					next_r.rx = {r.rx[30:0], r.miso_sync[1]};
					next_r.phase = ST_HIGH;
				end
			end
			ST_HIGH: begin
				next_r.div = r.div + 1'b1;
				if (r.div == spi_prog_pkg::SCK_HALF_CYC - 1'b1) begin
					next_r.div = '0;
					next_r.sck = 1'b0;
					if (r.bit_cnt == 5'd31) begin
						next_r.resp = r.rx;
						next_r.phase = ST_IDLE;
					end else begin
						next_r.bit_cnt = r.bit_cnt + 1'b1;
						next_r.tx = {r.tx[30:0], 1'b0};
						next_r.mosi = r.tx[30];
						next_r.phase = ST_LOW;
					end
				end
			end
			default: next_r.phase = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '0;
			r.phase <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// outputs from flops; busy polling and byte order stay with software
	assign rdata_o    = r.rdata;
	assign link.rst_n = ~r.hold;
	assign link.sck   = r.sck;
	assign link.mosi  = r.mosi;
endmodule
`default_nettype wire

/* File: spi_prog_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the four link wires between programmer and target
module spi_prog_link_sva (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// link wires
	input wire logic rst_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	logic        sck_q;	// sck one cycle ago
	int unsigned rises;	// sck rises since the link reset went low
	int unsigned idle;	// cycles without an sck edge, saturating

	// count bits of the running session; a released link reset aborts it
	always_ff @(posedge clk_sys_i) begin
		sck_q <= sck;
		if (srst_i || rst_n) begin
			rises <= 0;
		end else if (sck && !sck_q) begin
			rises <= rises + 1;
		end
		if (srst_i || (sck != sck_q)) begin
			idle <= 0;
		end else if (idle < 50) begin
			idle <= idle + 1;
		end
	end

	sck_high_len_a: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("serial clock high phase is not eight cycles");
	sck_low_len_a: assert property ($fell(sck) |-> !sck[*8])
		else $error("serial clock low phase shorter than eight cycles");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("data toward target moved while clock high");
	miso_edge_a: assert property ($changed(miso) |-> !sck)
		else $error("data toward programmer moved while clock high");
	link_sync_a: assert property ($rose(sck) && !rst_n |-> $past(rst_n, 3) == 1'b0)
		else $error("clock rose too soon after link reset went low");
	miso_quiet_a: assert property (rst_n[*6] |-> !miso)
		else $error("target drives data while link reset is released");
	frame_bits_a: assert property (idle == 40 && !rst_n |-> (rises % 32) == 0)
		else $error("frame ended after a bit count not a multiple of 32");
	reset_idle_a: assert property ($fell(srst_i) |-> rst_n && !sck)
		else $error("link not idle when reset ends");
endmodule
`default_nettype wire

/* File: test_serial_program_cmd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// drives the programmer's register port and judges both ends
module test_serial_program_cmd_decoder;
	// clock, reset and register port
	logic        clk_sys_i;
	logic        srst_i;
	logic [3:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	// target configuration outputs
	logic        prog_mode_o;
	logic        busy_o;
	logic [5:0]  lock_bits_o;
	logic [7:0]  fuse_low_o;
	logic [7:0]  fuse_high_o;
	logic [3:0]  fuse_ext_o;
	// bookkeeping
	int          n_mismatch;	// failed comparisons
	int          compares;	// comparisons made
	logic [31:0] resp;	// answer word of the last instruction

	spi_prog_link_if spi_prog_link_if_i ();
	spi_prog_programmer spi_prog_programmer_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(spi_prog_link_if_i));
	// eeprom wait outlasts one poll frame, so a busy answer can be seen
	spi_prog_target #(.FUSE_WAIT_CYC(200), .FLASH_WAIT_CYC(200), .EE_WAIT_CYC(2000), .ERASE_WAIT_CYC(200))
	spi_prog_target_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(spi_prog_link_if_i),
		.prog_mode_o(prog_mode_o), .busy_o(busy_o), .lock_bits_o(lock_bits_o), .fuse_low_o(fuse_low_o),
		.fuse_high_o(fuse_high_o), .fuse_ext_o(fuse_ext_o));
	spi_prog_link_sva spi_prog_link_sva_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.rst_n(spi_prog_link_if_i.rst_n), .sck(spi_prog_link_if_i.sck), .mosi(spi_prog_link_if_i.mosi),
		.miso(spi_prog_link_if_i.miso));

	// free-running system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// prints the verdict and stops
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// compares one result word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle register write
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	// one-cycle register read, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		d = rdata_o;
	endtask

	// waits, bounded, until the programmer has stopped shifting
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h1;
		for (int j = 0; j < 1000 && s[0] !== 1'b0; j++) begin
			rd(4'h8, s);
		end
	endtask

	// sends one instruction and fetches its answer word
	task automatic cmd(input logic [31:0] c);
		wr(4'h0, c);
		wait_idle;
		rd(4'h4, resp);
	endtask

	// sends a read instruction and compares byte four
	task automatic rd_cmp(input logic [31:0] c, input logic [7:0] e);
		cmd(c);
		chk(resp & 32'hff, {24'h0, e});
	endtask

	// polls the busy flag until it reads zero
	task automatic poll_ready;
		resp = 32'h1;
		for (int j = 0; j < 40 && resp[0] !== 1'b0; j++) begin
			cmd(32'hf0000000);
		end
		chk(resp & 32'h1, 32'h0);
	endtask

	// writes before enable are ignored, then enable echoes its selector
	task automatic t_enable;
		wr(4'hc, 32'h1);
		// the hold flop updates at the edge the write task ends on; look once it has settled
		@(negedge clk_sys_i);
		chk({31'h0, spi_prog_link_if_i.rst_n}, 32'h0);
		cmd(32'haca00000);
		chk({24'h0, fuse_low_o}, 32'hff);
		cmd(32'hac530000);
		chk({24'h0, resp[15:8]}, 32'h53);
		chk({31'h0, prog_mode_o}, 32'h1);
	endtask

	// fuse and lock writes, then every configuration read
	task automatic t_config;
		cmd(32'haca0005a);
		poll_ready;
		cmd(32'haca800a5);
		poll_ready;
		cmd(32'haca40003);
		poll_ready;
		chk({12'h0, fuse_low_o, fuse_high_o, fuse_ext_o}, 32'h0005aa53);
		cmd(32'hace000ea);
		poll_ready;
		chk({26'h0, lock_bits_o}, 32'h2a);
		rd_cmp(32'h50000000, 8'h5a);
		rd_cmp(32'h58080000, 8'ha5);
		rd_cmp(32'h50080000, 8'hf3);
		rd_cmp(32'h58000000, 8'hea);
	endtask

	// erase, then two flash pages written and read back by halves
	task automatic t_flash;
		cmd(32'hac800000);
		cmd(32'hf0000000);
		chk(resp & 32'h1, 32'h1);
		chk({31'h0, busy_o}, 32'h1);
		for (int j = 0; j < 70000 && busy_o !== 1'b0; j++) begin
			@(posedge clk_sys_i);
		end
		poll_ready;
		chk({26'h0, lock_bits_o}, 32'h3f);
		cmd(32'h40000534);
		cmd(32'h48000512);
		cmd(32'h4c000000);
		poll_ready;
		rd_cmp(32'h20000500, 8'h34);
		rd_cmp(32'h28000500, 8'h12);
		rd_cmp(32'h20010600, 8'hff);
		cmd(32'h40000577);
		cmd(32'h4c008000);
		poll_ready;
		rd_cmp(32'h20008500, 8'h77);
		rd_cmp(32'h20000500, 8'h34);
	endtask

	// eeprom byte write with busy seen, then a page write
	task automatic t_eeprom;
		cmd(32'hc0012377);
		cmd(32'hf0000000);
		chk(resp & 32'h1, 32'h1);
		poll_ready;
		cmd(32'hc1000299);
		cmd(32'hc1000388);
		cmd(32'hc2012800);
		poll_ready;
		rd_cmp(32'ha0012300, 8'h77);
		rd_cmp(32'ha0112300, 8'h77);
		rd_cmp(32'ha0012a00, 8'h99);
		rd_cmp(32'ha0012b00, 8'h88);
		rd_cmp(32'ha0000500, 8'hff);
	endtask

	// link reset released mid-frame drops the session; a new one syncs
	task automatic t_resync;
		logic [31:0] v;	// register read back
		wr(4'h0, 32'h50000000);
		repeat (200) @(posedge clk_sys_i);
		wr(4'hc, 32'h0);
		wait_idle;
		chk({31'h0, prog_mode_o}, 32'h0);
		wr(4'hc, 32'h1);
		cmd(32'hac530000);
		chk({24'h0, resp[15:8]}, 32'h53);
		chk({31'h0, prog_mode_o}, 32'h1);
		rd(4'hc, v);
		chk(v, 32'h1);
		rd(4'h0, v);
		chk(v, 32'hac530000);
	endtask

	// main sequence
	initial begin
		srst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		n_mismatch = 0;
		compares = 0;
		repeat (12) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		t_enable;
		t_config;
		t_flash;
		t_eeprom;
		t_resync;
		complete_run;
	end

	// hang guard, a little beyond the expected run of about 91k cycles (erase walk dominates)
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire
